/* hw/tcp_defs.svh */
`ifndef TCP_DEFS_SVH
`define TCP_DEFS_SVH

// Register byte offsets on the Avalon-MM slave
`define TCP_OFS_CTRL0 5'h00
`define TCP_OFS_CTRL1 5'h04
`define TCP_OFS_CNT_LO 5'h08
`define TCP_OFS_CNT_HI 5'h0C
`define TCP_OFS_CMPA_LO 5'h10
`define TCP_OFS_CMPA_HI 5'h14
`define TCP_OFS_STATUS 5'h18

// Reset values
`define TCP_RST_BYTE 8'h00
`define TCP_RST_CNT 10'h000

// Counter limits and comparator P alignment (period code sits at bits 9..7)
`define TCP_CNT_MAX 10'h3FF
`define TCP_CNT_FULL 11'h400
`define TCP_CNT_ONE 11'h001
`define TCP_P_PAD 7'h00
`define TCP_PER_ZERO 3'h0

// Status bit positions
`define TCP_STAT_A 0
`define TCP_STAT_P 1

// Pin function codes, compare mode
`define TCP_CMP_KEEP 2'h0
`define TCP_CMP_LOW 2'h1
`define TCP_CMP_HIGH 2'h2
`define TCP_CMP_TOGGLE 2'h3

// Pin function codes, PWM mode
`define TCP_PWM_INACT 2'h0
`define TCP_PWM_ACT 2'h1
`define TCP_PWM_WAVE 2'h2
`define TCP_PWM_PULSE 2'h3

`endif

/* hw/tcp_pkg.sv */
package tcp_pkg;

   // Operating mode codes
   typedef enum logic [1:0] {
      MODE_CMP = 2'h0,
      MODE_CAP = 2'h1,
      MODE_PWM = 2'h2,
      MODE_TC = 2'h3
   } tcp_mode_type;

   // First control register layout
   typedef struct packed {
      logic counter_pause;
      logic [2:0] spare;
      logic counter_on;
      logic [2:0] period_value;
   } tcp_ctrl0_type;

   // Second control register layout
   typedef struct packed {
      tcp_mode_type mode_select;
      logic [1:0] pin_function_select;
      logic output_initial_level;
      logic output_invert;
      logic period_duty_swap;
      logic clear_source_select;
   } tcp_ctrl1_type;

endpackage

/* hw/tcp_timer.sv */
`timescale 1ns/10ps
`include "tcp_defs.svh"
// Function
// RQ1: Counter bits 7..0 readable in a read-only low byte, zero after reset.
// RQ2: Counter bits 9..8 read in bits 1..0 of high register; upper bits zero.
// RQ3: Comparator A value held in writable low and high registers, reset zero.
// RQ4: Mode field picks compare, PWM or timer/counter operation.
// RQ5: Compare, clear select low: clear on P match or overflow; both flags raise.
// RQ6: Compare, clear select high: clear on A match; P flag never raised.
// RQ7: Zero comparator A value: counter overflows at 3FF, no A flag.
// RQ8: Compare mode pin changes only on A match, never on P match.
// RQ9: On A match pin goes high, low or toggles by pin function; zero keeps.
// RQ10: Counter switching on drives pin to the chosen initial level.
// RQ11: Timer/counter mode counts and flags like compare, leaves pin undriven.
// RQ12: Software selects PWM mode and PWM pin function for waveform output.
// RQ13: PWM ignores clear select; period comparator clears the counter.
// RQ14: Swap clear: period code sets period and clears, comparator A sets duty.
// RQ15: Swap clear: period is 128 clocks times code, code zero gives 1024.
// RQ16: Duty at or above period keeps output active the whole period.
// RQ17: Swap set: comparator A sets period and clears; period code sets duty.
// RQ18: PWM raises A flag on A match and P flag on P match.
// RQ19: Initial level picks PWM polarity; pin function enables or forces level.
// RQ20: Forced pin levels leave counter, comparisons and flags running.
// RQ21: Invert bit inverts the output waveform at the pin.
// RQ22: Compare pin codes: keep, low, high, toggle on A match.
// RQ23: Period code matches counter bits 9..7, so at multiples of 128.
// RQ24: Switching on zeroes the counter; switching off freezes it.
// RQ25: Pause holds the counter; clearing pause resumes from that value.
// RQ26: Match flags stay set until software clears them.
// RQ27: Counter increments once per enabled tick while on and not paused.
module tcp_timer
   import tcp_pkg::*;
#(
   parameter int TICK_DIV = 1
) (
   // Clock and reset
   input wire logic CLOCK_I,
   input wire logic ARST_N_I,
   // Avalon-MM slave
   input wire logic [4:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   // Timer output pin
   output logic TM_PIN_O,
   output logic TM_PIN_OE_O,
   // Sticky match flags
   output logic COMPARE_A_FLAG_O,
   output logic COMPARE_P_FLAG_O
);

   localparam int DIV_W = $clog2(TICK_DIV + 1);

   logic ack_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic wr_go;
   logic [7:0] wdat;
   logic wr_ctrl0;
   logic wr_ctrl1;
   logic wr_cmpa_lo;
   logic wr_cmpa_hi;
   logic wr_status;
   tcp_ctrl0_type ctrl0_q;
   tcp_ctrl0_type new_ctrl0;
   tcp_ctrl1_type ctrl1_q;
   logic [9:0] cmpa_q;
   logic [9:0] cnt_q;
   logic [DIV_W-1:0] div_q;
   logic tick;
   logic run;
   logic step;
   logic start;
   logic [10:0] nxt;
   logic [10:0] p_cmp;
   logic [10:0] duty;
   logic match_a;
   logic match_p;
   logic is_pwm;
   logic clr_by_a;
   logic clear;
   logic set_a;
   logic set_p;
   logic clr_a;
   logic clr_p;
   logic flag_a_q;
   logic flag_p_q;
   logic cmp_lvl_q;
   logic pwm_act;
   logic pin_d;
   logic pin_q;
   logic oe_q;

   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (!ARST_N_I);

   // One wait state per access; read data is latched in the first cycle
   assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
   assign AVS_READDATA_O = rdata_q;

   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
      end
   end

   // Writes take effect at the edge where waitrequest is low; only lane 0 holds data
   assign wr_go = AVS_WRITE_I & ack_q & AVS_BYTEENABLE_I[0];
   assign wdat = AVS_WRITEDATA_I[7:0];
   assign wr_ctrl0 = wr_go && (AVS_ADDRESS_I == `TCP_OFS_CTRL0);
   assign wr_ctrl1 = wr_go && (AVS_ADDRESS_I == `TCP_OFS_CTRL1);
   assign wr_cmpa_lo = wr_go && (AVS_ADDRESS_I == `TCP_OFS_CMPA_LO);
   assign wr_cmpa_hi = wr_go && (AVS_ADDRESS_I == `TCP_OFS_CMPA_HI);
   assign wr_status = wr_go && (AVS_ADDRESS_I == `TCP_OFS_STATUS);
   assign new_ctrl0 = tcp_ctrl0_type'(wdat);

   // Read mux; unmapped addresses and reserved bits read zero
   always_comb begin
      rdata_d = '0;
      unique case (AVS_ADDRESS_I)
         `TCP_OFS_CTRL0: rdata_d[7:0] = ctrl0_q;
         `TCP_OFS_CTRL1: rdata_d[7:0] = ctrl1_q;
         `TCP_OFS_CNT_LO: rdata_d[7:0] = cnt_q[7:0]; // [RQ1]
         `TCP_OFS_CNT_HI: rdata_d[1:0] = cnt_q[9:8]; // [RQ2]
         `TCP_OFS_CMPA_LO: rdata_d[7:0] = cmpa_q[7:0];
         `TCP_OFS_CMPA_HI: rdata_d[1:0] = cmpa_q[9:8];
         `TCP_OFS_STATUS: rdata_d[1:0] = {flag_p_q, flag_a_q};
         default: rdata_d = '0;
      endcase
   end

   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         rdata_q <= '0;
      end else if (AVS_READ_I & ~ack_q) begin
         rdata_q <= rdata_d;
      end
   end

   // Control registers; clock-select bits are not built, so they stay zero
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ctrl0_q <= tcp_ctrl0_type'(`TCP_RST_BYTE);
         ctrl1_q <= tcp_ctrl1_type'(`TCP_RST_BYTE);
      end else begin
         if (wr_ctrl0) begin
            ctrl0_q <= new_ctrl0;
            ctrl0_q.spare <= '0;
         end
         if (wr_ctrl1) begin
            ctrl1_q <= tcp_ctrl1_type'(wdat); // [RQ4]
         end
      end
   end

   // Comparator A value, split over two byte registers
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         cmpa_q <= `TCP_RST_CNT;
      end else begin
         if (wr_cmpa_lo) begin
            cmpa_q[7:0] <= wdat; // [RQ3]
         end
         if (wr_cmpa_hi) begin
            cmpa_q[9:8] <= wdat[1:0]; // [RQ3]
         end
      end
   end

   // Tick divider stands in for the selectable module clock
   assign tick = (div_q == DIV_W'(TICK_DIV - 1));

   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         div_q <= '0;
      end else if (tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   // Match detection looks one count ahead so a period of N holds exactly N ticks
   assign start = wr_ctrl0 & new_ctrl0.counter_on & ~ctrl0_q.counter_on;
   assign run = ctrl0_q.counter_on & ~ctrl0_q.counter_pause; // [RQ25]
   assign step = tick & run;
   assign nxt = {1'b0, cnt_q} + `TCP_CNT_ONE;
   assign p_cmp = (ctrl0_q.period_value == `TCP_PER_ZERO) ? `TCP_CNT_FULL :
                  {1'b0, ctrl0_q.period_value, `TCP_P_PAD}; // [RQ15]
   assign match_p = (nxt == p_cmp); // [RQ23]
   assign match_a = (cmpa_q != `TCP_RST_CNT) && (nxt == {1'b0, cmpa_q}); // [RQ7]
   assign is_pwm = (ctrl1_q.mode_select == MODE_PWM);
   // PWM takes the clear from the swap bit, other modes from clear select
   assign clr_by_a = is_pwm ? ctrl1_q.period_duty_swap : ctrl1_q.clear_source_select; // [RQ13]
   assign clear = clr_by_a ? match_a : match_p; // [RQ5] [RQ6] [RQ14] [RQ17]

   // Counter; a zero-value comparator leaves the natural wrap at the maximum
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         cnt_q <= `TCP_RST_CNT;
      end else if (start) begin
         cnt_q <= `TCP_RST_CNT; // [RQ24]
      end else if (step) begin
         cnt_q <= clear ? `TCP_RST_CNT : nxt[9:0]; // [RQ27] [RQ11]
      end
   end

   // Flag events; P is suppressed when comparator A owns the clear outside PWM
   assign set_a = step & match_a; // [RQ18]
   assign set_p = step & match_p & (is_pwm | ~ctrl1_q.clear_source_select); // [RQ6] [RQ18]
   assign clr_a = wr_status & wdat[`TCP_STAT_A];
   assign clr_p = wr_status & wdat[`TCP_STAT_P];

   // Sticky flags, write one to clear; a new event beats a same-cycle clear
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         flag_a_q <= 1'b0;
         flag_p_q <= 1'b0;
      end else begin
         flag_a_q <= set_a | (flag_a_q & ~clr_a); // [RQ26]
         flag_p_q <= set_p | (flag_p_q & ~clr_p); // [RQ26]
      end
   end

   assign COMPARE_A_FLAG_O = flag_a_q;
   assign COMPARE_P_FLAG_O = flag_p_q;

   // Compare-mode pin level, moved only by comparator A events and by switch-on
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         cmp_lvl_q <= 1'b0;
      end else if (start) begin
         cmp_lvl_q <= ctrl1_q.output_initial_level; // [RQ10]
      end else if (set_a && (ctrl1_q.mode_select == MODE_CMP)) begin // [RQ8]
         unique case (ctrl1_q.pin_function_select) // [RQ9] [RQ22]
            `TCP_CMP_KEEP: cmp_lvl_q <= cmp_lvl_q;
            `TCP_CMP_LOW: cmp_lvl_q <= 1'b0;
            `TCP_CMP_HIGH: cmp_lvl_q <= 1'b1;
            `TCP_CMP_TOGGLE: cmp_lvl_q <= ~cmp_lvl_q;
         endcase
      end
   end

   // Edge-aligned PWM: active while the count is below the duty value
   assign duty = ctrl1_q.period_duty_swap ? p_cmp : {1'b0, cmpa_q}; // [RQ14] [RQ17]
   assign pwm_act = ({1'b0, cnt_q} < duty); // [RQ16]

   // Pin value; single pulse is not built and rests inactive
   always_comb begin
      pin_d = 1'b0;
      unique case (ctrl1_q.mode_select)
         MODE_CMP: pin_d = cmp_lvl_q ^ ctrl1_q.output_invert;
         MODE_PWM: begin
            unique case (ctrl1_q.pin_function_select) // [RQ19] [RQ20]
               `TCP_PWM_INACT: pin_d = ~ctrl1_q.output_initial_level;
               `TCP_PWM_ACT: pin_d = ctrl1_q.output_initial_level;
               `TCP_PWM_WAVE: pin_d = pwm_act ? ctrl1_q.output_initial_level : ~ctrl1_q.output_initial_level;
               `TCP_PWM_PULSE: pin_d = ~ctrl1_q.output_initial_level;
            endcase
            pin_d = pin_d ^ ctrl1_q.output_invert; // [RQ21]
         end
         MODE_CAP: pin_d = 1'b0;
         MODE_TC: pin_d = 1'b0;
      endcase
   end

   // Registered pin; timer/counter and capture release the pin
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         pin_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         pin_q <= pin_d;
         oe_q <= (ctrl1_q.mode_select == MODE_CMP) || is_pwm; // [RQ11]
      end
   end

   assign TM_PIN_O = pin_q;
   assign TM_PIN_OE_O = oe_q;

   // Switching on leaves the counter at zero and the level at its initial value
   cnt_on_start_a: assert property ($rose(ctrl0_q.counter_on) |-> (cnt_q == `TCP_RST_CNT) && // [RQ24]
      (cmp_lvl_q == ctrl1_q.output_initial_level))
      else $error("counter or level not reset at switch-on");

   // No tick movement while off or paused
   cnt_hold_a: assert property ((!run && !start) |=> $stable(cnt_q)) // [RQ25]
      else $error("counter moved while stopped or paused");

   // Plain increment on an enabled tick
   cnt_step_a: assert property ((step && !clear && !start) |=> (cnt_q == $past(nxt[9:0]))) // [RQ27]
      else $error("counter did not step by one");

   // Period match with the P comparator clearing returns the counter to zero
   p_clear_a: assert property ((step && match_p && !clr_by_a && !start) |=> (cnt_q == `TCP_RST_CNT)) // [RQ23]
      else $error("period match did not clear counter");

   // Flag A holds until cleared by software
   flag_sticky_a: assert property ((flag_a_q && !clr_a) |=> flag_a_q [*2] or (flag_a_q ##1 clr_a)) // [RQ26]
      else $error("comparator A flag dropped without clear");

   // Comparator A clearing in compare mode never raises the P flag
   no_p_flag_a: assert property ((!is_pwm && ctrl1_q.clear_source_select && !flag_p_q && !clr_p) |=>
      !flag_p_q) // [RQ6]
      else $error("P flag raised while A clears counter");

   // A zero comparator value never raises the A flag
   zero_a_flag_a: assert property ((cmpa_q == `TCP_RST_CNT && !flag_a_q && !clr_a) |=> !flag_a_q) // [RQ7]
      else $error("A flag raised with zero compare value");

   // Timer/counter mode releases the pin
   tc_pin_off_a: assert property ((ctrl1_q.mode_select == MODE_TC) |=> !TM_PIN_OE_O) // [RQ11]
      else $error("pin driven in timer/counter mode");

   // Forced active level in PWM mode
   pwm_force_a: assert property ((is_pwm && ctrl1_q.pin_function_select == `TCP_PWM_ACT) |=>
      (TM_PIN_O == ($past(ctrl1_q.output_initial_level) ^ $past(ctrl1_q.output_invert)))) // [RQ19]
      else $error("forced active PWM level wrong");

   // Keep code leaves the compare level alone
   cmp_keep_a: assert property ((ctrl1_q.mode_select == MODE_CMP && ctrl1_q.pin_function_select ==
      `TCP_CMP_KEEP && !start) |=> $stable(cmp_lvl_q)) // [RQ9]
      else $error("compare level changed with keep code");

   // Flag P holds until cleared by software
   flag_p_sticky_a: assert property ((flag_p_q && !clr_p) |=> flag_p_q) // [RQ26]
      else $error("comparator P flag dropped without clear");

   // An A match event always lands in the A flag
   a_flag_set_a: assert property (set_a |=> flag_a_q) // [RQ18]
      else $error("A match did not set the A flag");

   // Comparator A owning the clear returns the counter to zero
   a_clear_a: assert property ((step && match_a && clr_by_a && !start) |=> (cnt_q == `TCP_RST_CNT)) // [RQ17]
      else $error("A match did not clear counter");

   // High code raises the compare level on an A match
   cmp_high_a: assert property ((set_a && !start && ctrl1_q.mode_select == MODE_CMP && // [RQ22]
      ctrl1_q.pin_function_select == `TCP_CMP_HIGH) |=> cmp_lvl_q)
      else $error("compare high code did not raise level");

   // Low code drops the compare level on an A match
   cmp_low_a: assert property ((set_a && !start && ctrl1_q.mode_select == MODE_CMP && // [RQ22]
      ctrl1_q.pin_function_select == `TCP_CMP_LOW) |=> !cmp_lvl_q)
      else $error("compare low code did not drop level");

   // Toggle code flips the compare level on an A match
   cmp_toggle_a: assert property ((set_a && !start && ctrl1_q.mode_select == MODE_CMP && // [RQ9]
      ctrl1_q.pin_function_select == `TCP_CMP_TOGGLE) |=> (cmp_lvl_q != $past(cmp_lvl_q)))
      else $error("compare toggle code did not flip level");

   // Only an A match or switch-on may move the compare level, so P matches never do
   cmp_pin_hold_a: assert property ((!set_a && !start) |=> $stable(cmp_lvl_q)) // [RQ8]
      else $error("compare level moved without A match");

   // Counter low byte reads the live count
   cnt_lo_read_a: assert property ((AVS_READ_I && !ack_q && AVS_ADDRESS_I == `TCP_OFS_CNT_LO) |=> // [RQ1]
      (AVS_READDATA_O == {24'h00_0000, $past(cnt_q[7:0])}))
      else $error("counter low byte read wrong");

   // Counter high register reads bits 9..8 with the rest zero
   cnt_hi_read_a: assert property ((AVS_READ_I && !ack_q && AVS_ADDRESS_I == `TCP_OFS_CNT_HI) |=> // [RQ2]
      (AVS_READDATA_O == {30'h0, $past(cnt_q[9:8])}))
      else $error("counter high bits read wrong");

   // PWM mode always drives the pin
   pwm_oe_a: assert property (is_pwm |=> TM_PIN_OE_O) // [RQ19]
      else $error("pin not driven in PWM mode");

   // Forced inactive level in PWM mode
   pwm_inact_a: assert property ((is_pwm && ctrl1_q.pin_function_select == `TCP_PWM_INACT) |=> // [RQ19]
      (TM_PIN_O != ($past(ctrl1_q.output_initial_level) ^ $past(ctrl1_q.output_invert))))
      else $error("forced inactive PWM level wrong");

endmodule

/* sim/tb_top.sv */
`timescale 1ns/10ps
`include "tcp_defs.svh"
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin mismatches++; $display("unexpected at %0t: %s got %0h exp %0h", $time, msg, got, exp); end end
module tb_top
   import tcp_pkg::*;
;
   logic CLOCK_I;
   logic ARST_N_I;
   logic [4:0] AVS_ADDRESS_I;
   logic AVS_READ_I;
   logic AVS_WRITE_I;
   logic [31:0] AVS_WRITEDATA_I;
   logic [31:0] AVS_READDATA_O;
   logic AVS_WAITREQUEST_O;
   logic TM_PIN_O;
   logic TM_PIN_OE_O;
   logic COMPARE_A_FLAG_O;
   logic COMPARE_P_FLAG_O;
   int mismatches;
   int checked;
   logic [31:0] rd;

   tcp_timer i_tcp_timer (.CLOCK_I(CLOCK_I), .ARST_N_I(ARST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
      .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
      .AVS_BYTEENABLE_I(4'h1), .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
      .TM_PIN_O(TM_PIN_O), .TM_PIN_OE_O(TM_PIN_OE_O), .COMPARE_A_FLAG_O(COMPARE_A_FLAG_O),
      .COMPARE_P_FLAG_O(COMPARE_P_FLAG_O));

   // Clock at 20 MHz
   initial begin
      CLOCK_I = 1'b0;
      forever #25 CLOCK_I = ~CLOCK_I;
   end

   // One register access; waitrequest and read data are sampled mid-cycle so they stand at the edge
   task automatic bus(input logic wr, input logic [4:0] addr, input logic [7:0] data);
      logic w;
      int n;
      @(posedge CLOCK_I);
      AVS_ADDRESS_I <= addr;
      AVS_WRITEDATA_I <= {24'h00_0000, data};
      AVS_READ_I <= ~wr;
      AVS_WRITE_I <= wr;
      n = 0;
      do begin
         @(negedge CLOCK_I);
         w = AVS_WAITREQUEST_O;
         rd = AVS_READDATA_O;
         @(posedge CLOCK_I);
         n++;
      end while (w !== 1'b0 && n < 100);
      AVS_READ_I <= 1'b0;
      AVS_WRITE_I <= 1'b0;
      `CHK(n < 100, 1'b1, "bus answer")
   endtask

   // Stop, clear flags, load compare A and mode, then switch on; control1 only changes while off
   task automatic start(input tcp_ctrl1_type c1, input logic [2:0] per, input logic [9:0] cmpa);
      bus(1'b1, `TCP_OFS_CTRL0, 8'h00);
      bus(1'b1, `TCP_OFS_STATUS, 8'h03);
      bus(1'b1, `TCP_OFS_CMPA_LO, cmpa[7:0]);
      bus(1'b1, `TCP_OFS_CMPA_HI, {6'h00, cmpa[9:8]});
      bus(1'b1, `TCP_OFS_CTRL1, c1);
      bus(1'b1, `TCP_OFS_CTRL0, {4'h0, 1'b1, per});
   endtask

   // Counts falling edges since switch-on; a flag set at edge k shows at falling edge k+1
   task automatic wait_flag(input logic pflag, inout int n);
      logic f;
      do begin
         @(negedge CLOCK_I);
         n++;
         f = pflag ? COMPARE_P_FLAG_O : COMPARE_A_FLAG_O;
      end while (f !== 1'b1 && n < 2000);
   endtask

   // Active cycles in a window of one period are phase independent
   task automatic count_high(input int win, output int h);
      h = 0;
      repeat (win) begin
         @(negedge CLOCK_I);
         if (TM_PIN_O === 1'b1) h++;
      end
   endtask

   task automatic t_regs();
      bus(1'b0, `TCP_OFS_CNT_LO, 8'h00);
      `CHK(rd, 32'h0000_0000, "counter low at reset")
      bus(1'b0, `TCP_OFS_CNT_HI, 8'h00);
      `CHK(rd, 32'h0000_0000, "counter high at reset")
      bus(1'b0, `TCP_OFS_CMPA_LO, 8'h00);
      `CHK(rd, 32'h0000_0000, "compare low at reset")
      bus(1'b0, `TCP_OFS_CMPA_HI, 8'h00);
      `CHK(rd, 32'h0000_0000, "compare high at reset")
      bus(1'b1, `TCP_OFS_CMPA_LO, 8'hA5);
      bus(1'b1, `TCP_OFS_CMPA_HI, 8'hFF);
      bus(1'b0, `TCP_OFS_CMPA_LO, 8'h00);
      `CHK(rd, 32'h0000_00A5, "compare low readback")
      bus(1'b0, `TCP_OFS_CMPA_HI, 8'h00);
      `CHK(rd, 32'h0000_0003, "compare high readback")
      bus(1'b1, `TCP_OFS_CNT_LO, 8'h55);
      bus(1'b0, `TCP_OFS_CNT_LO, 8'h00);
      `CHK(rd, 32'h0000_0000, "counter low ignores writes")
      bus(1'b0, 5'h1C, 8'h00);
      `CHK(rd, 32'h0000_0000, "unmapped read")
      $display("end of register test");
   endtask

   // Compare mode, clear on A, every pin code
   task automatic t_cmp_a();
      logic [1:0] fn;
      logic e;
      int n;
      for (int i = 0; i < 4; i++) begin
         fn = i[1:0];
         start(tcp_ctrl1_type'{MODE_CMP, fn, fn[0], 1'b0, 1'b0, 1'b1}, 3'h1, 10'h0C8);
         n = 0;
         repeat (3) @(negedge CLOCK_I);
         `CHK(TM_PIN_O, fn[0], "initial level")
         `CHK(TM_PIN_OE_O, 1'b1, "pin enabled")
         n = 3;
         wait_flag(1'b0, n);
         `CHK(n - 1, 200, "compare A match time")
         repeat (3) @(negedge CLOCK_I);
         e = (fn == `TCP_CMP_LOW) ? 1'b0 : (fn == `TCP_CMP_HIGH) ? 1'b1 : fn[0] ^ (fn == `TCP_CMP_TOGGLE);
         `CHK(TM_PIN_O, e, "pin after A match")
         `CHK(COMPARE_P_FLAG_O, 1'b0, "no P flag with clear on A")
      end
      $display("end of compare A test");
   endtask

   // Compare mode, clear on P; P match must not touch the pin
   task automatic t_cmp_p();
      int n;
      start(tcp_ctrl1_type'{MODE_CMP, `TCP_CMP_TOGGLE, 1'b0, 1'b0, 1'b0, 1'b0}, 3'h1, 10'h040);
      n = 0;
      wait_flag(1'b0, n);
      `CHK(n - 1, 64, "A match before period")
      wait_flag(1'b1, n);
      `CHK(n - 1, 128, "P match at code times 128")
      repeat (3) @(negedge CLOCK_I);
      `CHK(TM_PIN_O, 1'b1, "pin kept through P match")
      $display("end of compare P test");
   endtask

   // Timer/counter: overflow with zero codes, then clear on A and sticky flags
   task automatic t_tc();
      int n;
      start(tcp_ctrl1_type'{MODE_TC, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0}, 3'h0, 10'h000);
      n = 0;
      wait_flag(1'b1, n);
      `CHK(n - 1, 1024, "overflow clear")
      `CHK(COMPARE_A_FLAG_O, 1'b0, "zero compare A never flags")
      `CHK(TM_PIN_OE_O, 1'b0, "pin released")
      start(tcp_ctrl1_type'{MODE_TC, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1}, 3'h1, 10'h064);
      n = 0;
      wait_flag(1'b0, n);
      `CHK(n - 1, 100, "timer mode A match")
      repeat (250) @(negedge CLOCK_I);
      bus(1'b1, `TCP_OFS_CTRL0, 8'h00);
      bus(1'b0, `TCP_OFS_STATUS, 8'h00);
      `CHK(rd, 32'h0000_0001, "flag stays set")
      bus(1'b1, `TCP_OFS_STATUS, 8'h03);
      bus(1'b0, `TCP_OFS_STATUS, 8'h00);
      `CHK(rd, 32'h0000_0000, "flags cleared")
      $display("end of timer test");
   endtask

   // PWM cases: swap, invert, period code, compare A, window, expected active cycles
   task automatic t_pwm();
      int cs [6][6] = '{'{0, 0, 1, 32, 128, 32}, '{0, 1, 1, 32, 128, 96}, '{0, 0, 2, 300, 256, 256},
                        '{1, 0, 1, 200, 200, 128}, '{0, 0, 0, 100, 1024, 100}, '{0, 0, 2, 256, 256, 256}};
      int h;
      for (int i = 0; i < 6; i++) begin
         start(tcp_ctrl1_type'{MODE_PWM, `TCP_PWM_WAVE, 1'b1, 1'(cs[i][1]), 1'(cs[i][0]), 1'b1}, 3'(cs[i][2]),
               10'(cs[i][3]));
         repeat (8) @(negedge CLOCK_I);
         count_high(cs[i][4], h);
         `CHK(h, cs[i][5], "active cycles per period")
         if (i == 0) begin
            `CHK({COMPARE_A_FLAG_O, COMPARE_P_FLAG_O}, 2'h3, "both PWM flags")
         end
      end
      $display("end of PWM test");
   endtask

   // Forced pin levels while the PWM engine keeps running
   task automatic t_force();
      int h;
      for (int i = 0; i < 2; i++) begin
         start(tcp_ctrl1_type'{MODE_PWM, 2'(i), 1'b1, 1'b0, 1'b0, 1'b0}, 3'h1, 10'h020);
         repeat (4) @(negedge CLOCK_I);
         count_high(128, h);
         `CHK(h, 128 * i, "forced level")
         `CHK({COMPARE_A_FLAG_O, COMPARE_P_FLAG_O}, 2'h3, "flags while forced")
      end
      $display("end of forced level test");
   endtask

   // Pause holds, off freezes, on restarts from zero
   task automatic t_onoff();
      logic [31:0] r1;
      start(tcp_ctrl1_type'{MODE_TC, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0}, 3'h0, 10'h000);
      repeat (100) @(negedge CLOCK_I);
      bus(1'b1, `TCP_OFS_CTRL0, 8'h88);
      bus(1'b0, `TCP_OFS_CNT_LO, 8'h00);
      r1 = rd;
      repeat (20) @(negedge CLOCK_I);
      bus(1'b0, `TCP_OFS_CNT_LO, 8'h00);
      `CHK(rd, r1, "paused counter holds")
      bus(1'b0, `TCP_OFS_CNT_HI, 8'h00);
      `CHK(rd, 32'h0000_0000, "high bits")
      bus(1'b1, `TCP_OFS_CTRL0, 8'h08);
      bus(1'b1, `TCP_OFS_CTRL0, 8'h00);
      bus(1'b0, `TCP_OFS_CNT_LO, 8'h00);
      `CHK(rd > r1 && rd < r1 + 8, 1'b1, "resumed from held value")
      r1 = rd;
      repeat (20) @(negedge CLOCK_I);
      bus(1'b0, `TCP_OFS_CNT_LO, 8'h00);
      `CHK(rd, r1, "off counter frozen")
      bus(1'b1, `TCP_OFS_CTRL0, 8'h08);
      bus(1'b0, `TCP_OFS_CNT_LO, 8'h00);
      `CHK(rd < 8, 1'b1, "on restarts from zero")
      $display("end of on and pause test");
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Watchdog sized well above the roughly five thousand cycles of the sequence
   initial begin
      repeat (40000) @(posedge CLOCK_I);
      mismatches++;
      print_verdict();
   end

   initial begin
      mismatches = 0;
      checked = 0;
      ARST_N_I = 1'b0;
      AVS_ADDRESS_I = 5'h00;
      AVS_READ_I = 1'b0;
      AVS_WRITE_I = 1'b0;
      AVS_WRITEDATA_I = 32'h0000_0000;
      repeat (16) @(posedge CLOCK_I);
      ARST_N_I <= 1'b1;
      t_regs();
      t_cmp_a();
      t_cmp_p();
      t_tc();
      t_pwm();
      t_force();
      t_onoff();
      print_verdict();
   end
endmodule
